// ===== hdl/erf_pkg.sv
// Package: register map, field positions and carriers for the receive filter
package erf_pkg;

  localparam logic [7:0] ADDR_CFG      = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_PHY      = 8'h34;
  localparam logic [7:0] ADDR_HASH_LO  = 8'h90;
  localparam logic [7:0] ADDR_HASH_HI  = 8'h94;
  localparam logic [7:0] ADDR_TYPE_ID  = 8'hb8;
  localparam logic [7:0] ADDR_USER_IO  = 8'hc0;
  localparam logic [7:0] ADDR_RX_STAT  = 8'hc4;

  localparam int CFG_COPY_ALL   = 4;
  localparam int CFG_MC_HASH    = 6;
  localparam int CFG_UC_HASH    = 7;
  localparam int CFG_BIG_FRAME  = 8;
  localparam int CFG_EXT_MATCH  = 9;
  localparam int CFG_KEEP_BADFCS = 19;
  localparam logic [31:0] CFG_RESET = 32'h0000_0800;

  localparam int ST_PHY_IDLE    = 2;
  localparam int UIO_RMII       = 0;

  localparam int DS_TYPE_MATCH  = 22;
  localparam int DS_VLAN        = 21;
  localparam int DS_PRIO_TAG    = 20;
  localparam int DS_PRIO_LSB    = 17;
  localparam int DS_CFI         = 16;
  localparam int DS_EXT_MATCH   = 15;
  localparam int DS_HASH_MATCH  = 14;
  localparam int DS_STORE       = 0;

  localparam logic [15:0] VLAN_TPID = 16'h8100;
  localparam logic [10:0] MAX_STD   = 11'd1518;
  localparam logic [10:0] MAX_BIG   = 11'd1536;
  localparam logic [10:0] MIN_LEN   = 11'd64;
  localparam logic [10:0] EAM_LIMIT = 11'd16;

  localparam int  MDC_DIV_HALF = 32;
  localparam logic [5:0] MDC_HALF = 6'(MDC_DIV_HALF - 1);
  localparam logic [5:0] PHY_BITS = 6'd32;

  typedef struct packed {
    logic       valid;
    logic       error;
    logic [3:0] nibble;
  } erf_mii_rx_t;

  typedef struct packed {
    logic       enable;
    logic       error;
    logic [3:0] nibble;
  } erf_mii_tx_t;

endpackage : erf_pkg

// ===== hdl/erf_rx_filter.sv
// Receive filter, management shift port and MII/RMII pin mapping
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module erf_rx_filter
  import erf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        rx_valid_in,
  input  wire logic        rx_error_in,
  input  wire logic [3:0]  rx_nibble_in,
  input  wire logic        collision_in,
  input  wire logic        fcs_ok,
  input  wire logic        ext_match_in,
  input  wire logic        tx_req_enable,
  input  wire logic        tx_req_error,
  input  wire logic [3:0]  tx_req_nibble,
  output var  logic        tx_enable_out,
  output var  logic        tx_error_out,
  output var  logic [3:0]  tx_nibble_out,
  output var  logic        collision_seen,
  output var  logic        frame_done,
  output var  logic [31:0] rx_desc_status,
  output var  logic        phy_done,
  output var  logic        mdc,
  output var  logic        mdio_out,
  output var  logic        mdio_oe,
  input  wire logic        mdio_in
);

  typedef enum logic [1:0] {ERF_IDLE = 2'b00, ERF_RUN = 2'b01,
                            ERF_END = 2'b11} erf_phy_state_t;

  logic [31:0]    cfg;
  logic [31:0]    hash_lo;
  logic [31:0]    hash_hi;
  logic [15:0]    type_id;
  logic [31:0]    user_io_config;
  logic [31:0]    phy_shift_register;
  erf_phy_state_t phy_state;
  logic [5:0]     phy_count;
  logic [5:0]     mdc_div;

  erf_mii_rx_t    rx_s1;
  erf_mii_rx_t    rx_s2;
  logic [1:0]     col_s;
  logic [1:0]     eam_s;
  logic [1:0]     mdio_s;
  logic           rmii_half;
  logic           rmii_sel;

  logic [47:0]    dest_addr_bits;
  logic [15:0]    type_field;
  logic [15:0]    tci;
  logic [11:0]    nib_cnt;
  logic           in_frame;
  logic           rx_bad;
  logic           ext_hit;
  logic [5:0]     hash_index;
  logic [63:0]    hash_vec;
  logic           hash_bit;
  logic           mc_hit;
  logic           uc_hit;
  logic [10:0]    byte_cnt;
  logic [10:0]    max_len;
  logic           size_ok;
  logic           fcs_pass;
  logic           is_vlan;
  logic           wr_en;

  assign wr_en    = psel && penable && pwrite && pready;
  assign rmii_sel = user_io_config[UIO_RMII];
  assign hash_vec = {hash_hi, hash_lo};

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_s1  <= '0;
      rx_s2  <= '0;
      col_s  <= 2'b00;
      eam_s  <= 2'b00;
      mdio_s <= 2'b00;
    end
    else
    begin
      rx_s1  <= {rx_valid_in, rx_error_in, rx_nibble_in};
      rx_s2  <= rx_s1;
      col_s  <= {col_s[0], collision_in};
      eam_s  <= {eam_s[0], ext_match_in};
      mdio_s <= {mdio_s[0], mdio_in};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg            <= CFG_RESET;
      hash_lo        <= '0;
      hash_hi        <= '0;
      type_id        <= '0;
      user_io_config <= '0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        ADDR_CFG:     cfg            <= pwdata;
        ADDR_HASH_LO: hash_lo        <= pwdata;
        ADDR_HASH_HI: hash_hi        <= pwdata;
        ADDR_TYPE_ID: type_id        <= pwdata[15:0];
        ADDR_USER_IO: user_io_config <= pwdata;
        default:      ;
      endcase
    end
  end

  // Zero-wait slave: ready in every access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          ADDR_CFG:     prdata <= cfg;
          ADDR_STATUS:  prdata <= 32'((phy_state == ERF_IDLE)) << ST_PHY_IDLE;
          ADDR_PHY:     prdata <= phy_shift_register;
          ADDR_HASH_LO: prdata <= hash_lo;
          ADDR_HASH_HI: prdata <= hash_hi;
          ADDR_TYPE_ID: prdata <= {16'h0000, type_id};
          ADDR_USER_IO: prdata <= user_io_config;
          ADDR_RX_STAT: prdata <= rx_desc_status;
          default:      prdata <= '0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reduced mode: two dibits form one nibble, low pair first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rmii_half <= 1'b0;
    else if (!rmii_sel || !rx_s2.valid)
      rmii_half <= 1'b0;
    else
      rmii_half <= !rmii_half;
  end

  logic [1:0] rmii_low;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rmii_low <= 2'b00;
    else if (!rmii_half)
      rmii_low <= rx_s2.nibble[1:0];
  end

  logic       nib_strobe;
  logic [3:0] nib_data;
  assign nib_strobe = rx_s2.valid && (!rmii_sel || rmii_half);
  assign nib_data   = rmii_sel ? {rx_s2.nibble[1:0], rmii_low}
                               : rx_s2.nibble;

  //////////////////////////////////////////////////////////////////////////////
  // Frame capture: address, type and tag fields by nibble position
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dest_addr_bits <= '0;
      type_field     <= '0;
      tci            <= '0;
      nib_cnt        <= '0;
      in_frame       <= 1'b0;
      rx_bad         <= 1'b0;
      ext_hit        <= 1'b0;
    end
    else if (nib_strobe)
    begin
      in_frame <= 1'b1;
      nib_cnt  <= nib_cnt + 12'd1;
      if (nib_cnt < 12'd12)
        dest_addr_bits[nib_cnt[3:0]*4 +: 4] <= nib_data;
      else if (nib_cnt >= 12'd24 && nib_cnt < 12'd28)
        type_field[{nib_cnt[1:0] ^ 2'b10, 2'b00} +: 4] <= nib_data;
      else if (nib_cnt >= 12'd28 && nib_cnt < 12'd32)
        tci[{nib_cnt[1:0] ^ 2'b10, 2'b00} +: 4] <= nib_data;
      if (rx_s2.error)
        rx_bad <= 1'b1;
      // Late assertion is ignored; the match window covers bytes 6 to 15 only
      if (cfg[CFG_EXT_MATCH] && eam_s[1] && nib_cnt >= 12'd12
          && nib_cnt[11:1] < EAM_LIMIT)
        ext_hit <= 1'b1;
    end
    else if (!rx_s2.valid)
    begin
      nib_cnt  <= '0;
      in_frame <= 1'b0;
      rx_bad   <= 1'b0;
      ext_hit  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Match logic
  for (genvar n = 0; n < 6; n++)
  begin : g_hash
    assign hash_index[n] = ^{dest_addr_bits[n],      dest_addr_bits[n + 6],
                             dest_addr_bits[n + 12], dest_addr_bits[n + 18],
                             dest_addr_bits[n + 24], dest_addr_bits[n + 30],
                             dest_addr_bits[n + 36],
                             dest_addr_bits[n + 42]};
  end

  assign hash_bit = hash_vec[hash_index];
  assign mc_hit   = cfg[CFG_MC_HASH] && dest_addr_bits[0]
                    && hash_bit;
  assign uc_hit   = cfg[CFG_UC_HASH] && !dest_addr_bits[0]
                    && hash_bit;
  assign byte_cnt = nib_cnt[11:1];
  assign max_len  = cfg[CFG_BIG_FRAME] ? MAX_BIG : MAX_STD;
  assign size_ok  = byte_cnt >= MIN_LEN && byte_cnt <= max_len
                    && !nib_cnt[0];  // Odd nibble count is misaligned
  assign fcs_pass = fcs_ok || cfg[CFG_KEEP_BADFCS];
  assign is_vlan  = type_field == VLAN_TPID;

  // Frame result at end of carrier; type-ID match never gates storing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_done     <= 1'b0;
      rx_desc_status <= '0;
    end
    else
    begin
      frame_done <= 1'b0;
      if (in_frame && !rx_s2.valid)
      begin
        frame_done <= 1'b1;
        rx_desc_status <= '0;
        rx_desc_status[DS_STORE] <= !rx_bad && size_ok && fcs_pass
          && (cfg[CFG_COPY_ALL] || mc_hit || uc_hit || ext_hit);
        rx_desc_status[DS_EXT_MATCH]  <= ext_hit;
        rx_desc_status[DS_HASH_MATCH] <= mc_hit || uc_hit;
        rx_desc_status[DS_TYPE_MATCH] <= type_field == type_id;
        rx_desc_status[DS_VLAN]       <= is_vlan;
        rx_desc_status[DS_PRIO_TAG]   <= is_vlan
                                         && tci[11:0] == 12'h000;
        if (is_vlan)
        begin
          rx_desc_status[DS_PRIO_LSB +: 3] <= tci[15:13];
          rx_desc_status[DS_CFI]           <= tci[12];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit pin mapping; reduced mode holds error low and hides collision
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_enable_out  <= 1'b0;
      tx_error_out   <= 1'b0;
      tx_nibble_out  <= '0;
      collision_seen <= 1'b0;
    end
    else
    begin
      tx_enable_out  <= tx_req_enable;
      tx_error_out   <= rmii_sel ? 1'b0 : tx_req_error;
      tx_nibble_out  <= tx_req_nibble;
      collision_seen <= rmii_sel ? 1'b0 : col_s[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Management shift: 32 rotations return bits to their places
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phy_state          <= ERF_IDLE;
      phy_shift_register <= '0;
      phy_count          <= '0;
      mdc_div            <= '0;
      mdc                <= 1'b0;
      mdio_out           <= 1'b0;
      mdio_oe            <= 1'b0;
      phy_done           <= 1'b0;
    end
    else
    begin
      phy_done <= 1'b0;
      unique case (phy_state)
        ERF_IDLE:
        begin
          mdc     <= 1'b0;
          mdio_oe <= 1'b0;
          if (wr_en && paddr == ADDR_PHY)
          begin
            phy_shift_register <= pwdata;
            phy_count          <= '0;
            mdc_div            <= '0;
            mdio_oe            <= 1'b1;
            mdio_out           <= pwdata[31];
            phy_state          <= ERF_RUN;
          end
        end
        ERF_RUN:
        begin
          mdc_div <= mdc_div + 6'd1;
          if (mdc_div == MDC_HALF)
          begin
            mdc_div <= '0;
            mdc     <= !mdc;
            if (mdc)
            begin
              phy_shift_register <= {phy_shift_register[30:0],
                                     mdio_s[1]};
              mdio_out  <= phy_shift_register[30];
              phy_count <= phy_count + 6'd1;
              if (phy_count == PHY_BITS - 6'd1)
                phy_state <= ERF_END;
            end
          end
        end
        ERF_END:
        begin
          mdio_oe   <= 1'b0;
          mdc       <= 1'b0;
          phy_done  <= 1'b1;
          phy_state <= ERF_IDLE;
        end
        default: phy_state <= ERF_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_hash_uc_gate: assert property (@(posedge pclk) disable iff (!presetn)
    uc_hit |-> cfg[CFG_UC_HASH] && !dest_addr_bits[0])
    else $error("unicast hash hit without enable");
  chk_hash_mc_gate: assert property (@(posedge pclk) disable iff (!presetn)
    mc_hit |-> cfg[CFG_MC_HASH] && dest_addr_bits[0])
    else $error("multicast hash hit without enable");
  chk_ext_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ext_hit) |-> $past(cfg[CFG_EXT_MATCH]))
    else $error("external match taken while disabled");
  chk_prio_vlan: assert property (@(posedge pclk) disable iff (!presetn)
    rx_desc_status[DS_PRIO_TAG] |-> rx_desc_status[DS_VLAN])
    else $error("priority tag without vlan tag");
  chk_bad_drop: assert property (@(posedge pclk) disable iff (!presetn)
    in_frame && !rx_s2.valid && rx_bad |=> !rx_desc_status[DS_STORE])
    else $error("errored frame stored");
  chk_rmii_txer: assert property (@(posedge pclk) disable iff (!presetn)
    rmii_sel |=> !tx_error_out)
    else $error("tx error driven in reduced mode");
  chk_phy_done: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(phy_done) |-> $past(phy_state) == ERF_END
                        && phy_state == ERF_IDLE)
    else $error("shift completion out of sequence");
  chk_mdio_msb: assert property (@(posedge pclk) disable iff (!presetn)
    phy_state == ERF_RUN && $stable(phy_shift_register) && mdio_oe
    |-> mdio_out == phy_shift_register[31])
    else $error("mdio not showing shift msb");

endmodule : erf_rx_filter

`default_nettype wire

// ===== dv/erf_phy_model.sv
// Behavioural PHY: receive stream, external match source and MDIO wire
`timescale 1ns/1ps
`default_nettype none
module erf_phy_model
(
  input  wire logic       pclk,
  input  wire logic       mdio_out,
  input  wire logic       mdio_oe,
  output var  logic       mdio_in,
  output var  logic       rx_valid_in,
  output var  logic       rx_error_in,
  output var  logic [3:0] rx_nibble_in,
  output var  logic       ext_match_in
);
  logic [7:0] frm [0:1536];

  // Pull-up holds the line high whenever the MAC lets go of it
  assign mdio_in = mdio_oe ? mdio_out : 1'b1;

  initial
  begin
    rx_valid_in  = 1'b0;
    rx_error_in  = 1'b0;
    rx_nibble_in = 4'h5;
    ext_match_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame, low nibble first; reduced mode sends two dibits per nibble
  task automatic send(input int len, input int err_at, input int ext_at,
                      input logic rmii);
    logic [3:0] nib;
    for (int i = 0; i < 2 * len; i++)
    begin
      nib = (i % 2) ? frm[i / 2][7:4] : frm[i / 2][3:0];
      for (int j = 0; j < (rmii ? 2 : 1); j++)
      begin
        @(posedge pclk);
        rx_valid_in  <= 1'b1;
        rx_nibble_in <= rmii ? {2'b00, j ? nib[3:2] : nib[1:0]} : nib;
        rx_error_in  <= (i / 2 == err_at);
        ext_match_in <= (i / 2 >= ext_at);
      end
    end
    @(posedge pclk);
    rx_valid_in  <= 1'b0;
    rx_error_in  <= 1'b0;
    ext_match_in <= 1'b0;
    // Idle data toggles so stale nibbles never pass for valid ones
    rx_nibble_in <= ~rx_nibble_in;
  endtask : send
endmodule : erf_phy_model
`default_nettype wire

// ===== dv/erf_rx_filter_test.sv
// Self-checking bench for the receive filter block
`timescale 1ns/1ps
`default_nettype none
module erf_rx_filter_test;
  import erf_pkg::*;
  localparam int NO = 9999;
  localparam logic [47:0] UDA = 48'h0a0b_0c0d_0e02;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, frame_done, phy_done, mdc, pslverr;
  logic        collision_in = 1'b0, fcs_ok = 1'b1, rmii = 1'b0;
  logic        tx_req_enable = 1'b0, tx_req_error = 1'b0;
  logic        tx_enable_out, tx_error_out, collision_seen;
  logic        rx_valid_in, rx_error_in, ext_match_in;
  logic        mdio_out, mdio_oe, mdio_in;
  logic [3:0]  rx_nibble_in, tx_req_nibble = 4'h0, tx_nibble_out;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rx_desc_status, rdat;
  int          error_cnt = 0, checks = 0, cyc = 0;

  always #4 pclk = ~pclk;

  erf_rx_filter i_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid_in(rx_valid_in),
    .rx_error_in(rx_error_in), .rx_nibble_in(rx_nibble_in),
    .collision_in(collision_in), .fcs_ok(fcs_ok),
    .ext_match_in(ext_match_in), .tx_req_enable(tx_req_enable),
    .tx_req_error(tx_req_error), .tx_req_nibble(tx_req_nibble),
    .tx_enable_out(tx_enable_out), .tx_error_out(tx_error_out),
    .tx_nibble_out(tx_nibble_out), .collision_seen(collision_seen),
    .frame_done(frame_done), .rx_desc_status(rx_desc_status),
    .phy_done(phy_done), .mdc(mdc), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .mdio_in(mdio_in)
  );

  erf_phy_model i_phy
  (
    .pclk(pclk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdio_in(mdio_in),
    .rx_valid_in(rx_valid_in), .rx_error_in(rx_error_in),
    .rx_nibble_in(rx_nibble_in), .ext_match_in(ext_match_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Every driver starts one edge on, so no signal is set twice in a step
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    logic e;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(32'(e), 0, "apb error");
  endtask : apb

  function automatic logic [5:0] hidx(input logic [47:0] d);
    logic [5:0] h;
    h = 6'h00;
    for (int k = 0; k < 48; k++)
      h[k % 6] ^= d[k];
    return h;
  endfunction : hidx

  task automatic frame(input logic [47:0] da, input logic [15:0] ty,
                       input logic [15:0] tci, input int len, input int err,
                       input int ext, input logic fcs, output logic [31:0] st);
    int n;
    n = 0;
    for (int i = 0; i < len; i++)
      i_phy.frm[i] = (i < 6) ? da[8 * i +: 8] : 8'(i);
    {i_phy.frm[12], i_phy.frm[13], i_phy.frm[14], i_phy.frm[15]} = {ty, tci};
    fcs_ok <= fcs;
    i_phy.send(len, err, ext, rmii);
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (frame_done !== 1'b1 && n < 20);
    st = rx_desc_status;
    chk(32'(n < 20), 1, "frame done");
  endtask : frame

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(0, ADDR_CFG, 0, rdat);
    chk(rdat, CFG_RESET, "cfg reset");
    apb(0, ADDR_TYPE_ID, 0, rdat);
    chk(rdat, 0, "type id reset");
    apb(1, 8'h0c, 32'hffff_ffff, rdat);
    apb(0, 8'h0c, 0, rdat);
    chk(rdat, 0, "unmapped");
  endtask : t_regs

  task automatic t_hash;
    logic [47:0] da [2];
    logic [63:0] hv;
    logic [31:0] st;
    logic [1:0]  e;
    da[0] = 48'hcba9_8765_4321;
    da[1] = 48'hcba9_8765_4320;
    hv = (64'h1 << hidx(da[0])) | (64'h1 << hidx(da[1]));
    for (int k = 0; k < 5; k++)
    begin
      e = (k == 4) ? 2'b11 : 2'(k);
      apb(1, ADDR_HASH_LO, (k < 4) ? hv[31:0] : 32'h0, rdat);
      apb(1, ADDR_HASH_HI, (k < 4) ? hv[63:32] : 32'h0, rdat);
      apb(0, ADDR_HASH_HI, 0, rdat);
      chk(rdat, (k < 4) ? hv[63:32] : 32'h0, "hash top");
      apb(1, ADDR_CFG, CFG_RESET | 32'(e[0]) << CFG_MC_HASH
          | 32'(e[1]) << CFG_UC_HASH, rdat);
      for (int u = 0; u < 2; u++)
      begin
        frame(da[u], 16'h0800, 16'h0, 64, NO, NO, 1'b1, st);
        chk(32'({st[DS_HASH_MATCH], st[DS_STORE]}),
            32'({2{k < 4 && e[u]}}), "hash");
      end
    end
  endtask : t_hash

  task automatic t_copy;
    int          ln [8] = '{64, 63, 64, 64, 64, 1519, 1536, 1537};
    int          er [8] = '{NO, NO, 20, NO, NO, NO, NO, NO};
    logic        fc [8] = '{1, 1, 1, 0, 0, 1, 1, 1};
    logic        xs [8] = '{1, 0, 0, 0, 1, 0, 1, 0};
    logic [31:0] st;
    for (int i = 0; i < 8; i++)
    begin
      apb(1, ADDR_CFG, CFG_RESET | 32'h1 << CFG_COPY_ALL
          | 32'(i == 4) << CFG_KEEP_BADFCS
          | 32'(i > 5) << CFG_BIG_FRAME, rdat);
      frame(UDA, 16'h0800, 16'h0, ln[i], er[i], NO, fc[i], st);
      chk(32'(st[DS_STORE]), 32'(xs[i]), "copy all");
    end
  endtask : t_copy

  task automatic t_vlan;
    logic [15:0] tid [4] = '{16'h8100, 16'h8100, 16'h0800, 16'h8100};
    logic [15:0] ty [4] = '{16'h8100, 16'h8100, 16'h0800, 16'h0800};
    logic [15:0] tc [4] = '{16'hb000, 16'h4abc, 16'hb000, 16'h0000};
    logic [31:0] st;
    logic        v;
    apb(1, ADDR_CFG, CFG_RESET, rdat);
    for (int i = 0; i < 4; i++)
    begin
      apb(1, ADDR_TYPE_ID, 32'(tid[i]), rdat);
      frame(UDA, ty[i], tc[i], 64, NO, NO, 1'b1, st);
      v = (ty[i] === VLAN_TPID);
      chk(32'(st[DS_TYPE_MATCH]), 32'(tid[i] === ty[i]), "type");
      chk(32'({st[DS_VLAN], st[DS_PRIO_TAG]}),
          32'({v, v && tc[i][11:0] == 12'h000}), "vlan");
      if (v)
        chk(32'({st[DS_PRIO_LSB +: 3], st[DS_CFI]}), 32'(tc[i][15:12]),
            "tci");
      chk(32'(st[DS_STORE]), 0, "type store");
    end
  endtask : t_vlan

  task automatic t_ext;
    int          at [3] = '{8, 8, 40};
    logic [31:0] st;
    for (int i = 0; i < 3; i++)
    begin
      apb(1, ADDR_CFG, CFG_RESET | 32'(i != 1) << CFG_EXT_MATCH, rdat);
      frame(UDA, 16'h0800, 16'h0, 64, NO, at[i], 1'b1, st);
      chk(32'(st[DS_STORE]), 32'(i == 0), "ext store");
      if (i < 2)
        chk(32'(st[DS_EXT_MATCH]), 32'(i == 0), "ext flag");
    end
  endtask : t_ext

  task automatic t_pins;
    logic [31:0] st;
    apb(1, ADDR_TYPE_ID, 32'h0000_0800, rdat);
    for (int m = 0; m < 2; m++)
    begin
      apb(1, ADDR_USER_IO, 32'(m), rdat);
      apb(1, ADDR_CFG, CFG_RESET | 32'h1 << CFG_COPY_ALL, rdat);
      rmii = m[0];
      collision_in  <= 1'b1;
      tx_req_enable <= 1'b1;
      tx_req_error  <= 1'b1;
      tx_req_nibble <= 4'ha;
      repeat (5) @(posedge pclk);
      chk(32'({collision_seen, tx_error_out, tx_enable_out}),
          32'({!m[0], !m[0], 1'b1}), "pins");
      if (m == 0)
        chk(32'(tx_nibble_out), 32'h0000_000a, "tx nibble");
      collision_in  <= 1'b0;
      tx_req_enable <= 1'b0;
      tx_req_error  <= 1'b0;
      frame(UDA, 16'h0800, 16'h0, 64, NO, NO, 1'b1, st);
      chk(32'(st[DS_STORE]), 1, "mode frame");
      chk(32'(st[DS_TYPE_MATCH]), 1, "mode type");
    end
  endtask : t_pins

  task automatic t_mdio;
    int   n, r;
    logic p;
    n = 0;
    r = 0;
    apb(1, ADDR_PHY, 32'h5092_abcd, rdat);
    apb(1, ADDR_PHY, 32'h0000_ffff, rdat);
    apb(0, ADDR_STATUS, 0, rdat);
    chk(32'({rdat[ST_PHY_IDLE], mdio_oe}), 32'h1, "shift busy");
    p = mdc;
    while (phy_done !== 1'b1 && n < 2400)
    begin
      @(posedge pclk);
      n++;
      r += int'(mdc === 1'b1 && p === 1'b0);
      p = mdc;
    end
    chk(32'(n > 1800 && n < 2400), 1, "shift time");
    chk(32'(r), 32, "mdc cycles");
    apb(0, ADDR_PHY, 0, rdat);
    chk(rdat, 32'h5092_abcd, "shift home");
    apb(0, ADDR_STATUS, 0, rdat);
    chk(32'(rdat[ST_PHY_IDLE]), 1, "shift idle");
  endtask : t_mdio

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // Longest run is the copy-all table of full-size frames
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      results();
    end
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_hash();
    t_copy();
    t_vlan();
    t_ext();
    t_pins();
    t_mdio();
    results();
  end
endmodule : erf_rx_filter_test
`default_nettype wire
